/* File: hw/spc_pkg.sv */
// Shared constants and types of the serial port block
package spc_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets on the APB
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DATA     = 8'h0C;

    // Reset values and writable-bit masks
    localparam logic [15:0] CTRL_ONE_RST  = 16'h0000;
    localparam logic [15:0] CTRL_TWO_RST  = 16'h0000;
    localparam logic [15:0] CTRL_ONE_MASK = 16'h1FFF;
    localparam logic [15:0] CTRL_TWO_MASK = 16'hE003;

    // Word lengths and edge counts inside a frame
    localparam logic [5:0] BITS_WIDE      = 6'h10;
    localparam logic [5:0] BITS_NARROW    = 6'h08;
    localparam logic [5:0] FRAMED_FIRST   = 6'h01;
    localparam logic [5:0] PULSE_EDGE_END = 6'h03;

    // Divider ratios: primary indexed by field value, secondary is the base minus the field
    localparam logic [6:0] PRI_RATIO [4] = '{7'h40, 7'h10, 7'h04, 7'h01};
    localparam logic [3:0] SEC_BASE      = 4'h8;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       clock_pin_disable;
        logic       data_out_pin_disable;
        logic       word_width_select;
        logic       input_sample_phase;
        logic       clock_edge_select;
        logic       select_pin_enable;
        logic       clock_idle_polarity;
        logic       master_select;
        logic [2:0] secondary_divider;
        logic [1:0] primary_divider;
    } spc_ctrl_one_t;

    typedef struct packed {
        logic        framed_enable;
        logic        frame_pulse_direction;
        logic        frame_pulse_polarity;
        logic [10:0] rsvd;
        logic        frame_pulse_edge;
        logic        enhanced_buffer_enable;
    } spc_ctrl_two_t;

    typedef struct packed {
        logic       port_enable;
        logic [7:0] rsvd_a;
        logic       rx_overflow;
        logic [3:0] rsvd_b;
        logic       tx_full;
        logic       rx_full;
    } spc_status_t;

    typedef struct packed {
        logic shift_clock_pin;
        logic serial_data_out_pin;
        logic select_or_sync_pin;
    } spc_pin_t;

    typedef struct packed {
        logic shift_clock_pin;
        logic serial_data_in_pin;
        logic select_or_sync_pin;
    } spc_pin_in_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SYNC  = 2'b01,
        ST_SHIFT = 2'b10
    } spc_state_t;

endpackage

/* File: hw/spc_fifo.sv */
// Word buffer with a run-time capacity limit
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic [AW:0]   limit,
    input  wire logic          push,
    input  wire logic [W-1:0]  wdata,
    input  wire logic          pop,
    output logic      [W-1:0]  rdata,
    output logic               full,
    output logic               empty
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [AW:0]   cnt;
    logic          do_push;
    logic          do_pop;

    // Full follows the limit, so one-entry mode back-pressures early
    assign full    = cnt >= limit;
    assign empty   = cnt == '0;
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;
    assign rdata   = mem[rp];

    // Storage needs no reset; reads of empty slots are masked upstream
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wp] <= wdata;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rp  <= '0;
            wp  <= '0;
            cnt <= '0;
        end else begin
            if (do_push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (do_pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

/* File: hw/spc_prescaler.sv */
// Half-period tick generator for the master shift clock
`timescale 1ns/1ps
`default_nettype none
module spc_prescaler (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [1:0] pri,
    input  wire logic [2:0] sec,
    output logic            tick
);
    logic [10:0] prod;
    logic [9:0]  half;
    logic [9:0]  cnt;

    // One clock period spans the product of both ratios; an odd product loses its last cycle
    assign prod = 11'(spc_pkg::PRI_RATIO[pri]) * 11'(spc_pkg::SEC_BASE - {1'b0, sec});
    // A 1:1 by 1:1 setting is not allowed; clamp keeps the counter sane
    assign half = (prod[10:1] == '0) ? 10'h001 : prod[10:1]; // RULE_12

    // Counter restarts whenever the clock is stopped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt + 10'h001 >= half) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 10'h001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hw/spc_port.sv */
// Serial port: APB registers, shift engine, framing and pin control
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01: Clock pin disable releases master clock pin.
// RULE_02: Data-out disable releases serial data pin.
// RULE_03: Width bit selects 16 or 8 bit words.
// RULE_04: Sample phase: end or middle of bit.
// RULE_05: Host keeps sample phase clear as slave.
// RULE_06: Edge bit picks which clock edge shifts.
// RULE_07: Framed mode ignores edge bit; host zeroes.
// RULE_08: Select enable makes slave obey select pin.
// RULE_09: Select enable and framed mode exclusive.
// RULE_10: Polarity bit sets idle clock level.
// RULE_11: Master bit chooses master or slave.
// RULE_12: Host never sets both dividers 1:1.
// RULE_13: Framed mode turns select pin into sync.
// RULE_14: Direction bit: sync input or output.
// RULE_15: Polarity bit: sync active high or low.
// RULE_16: Sync pulse with or before first bit.
// RULE_17: Buffer bit enables multi-entry buffering.
// RULE_18: Unused bits read zero; all reset zero.
// RULE_19: Host sets sample phase with/after master.
// RULE_20: Framed mode runs clock continuously.
// RULE_21: Port enable claims the serial pins.
// RULE_22: Master clock divided by both dividers.
// RULE_23: Words shift most significant bit first.
module spc_port #(
    parameter int DEPTH = 8
) (
    input  wire logic                         mclk,
    input  wire logic                         reset,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [spc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire spc_pkg::spc_pin_in_t         pin_in,
    output var  spc_pkg::spc_pin_t            pin_out,
    output var  spc_pkg::spc_pin_t            pin_oe
);
    localparam int AW = $clog2(DEPTH);

    spc_pkg::spc_ctrl_one_t c1;
    spc_pkg::spc_ctrl_two_t c2;
    spc_pkg::spc_status_t   status;
    spc_pkg::spc_status_t   wstat;
    spc_pkg::spc_pin_in_t   pin_s;
    spc_pkg::spc_state_t    st;
    logic                   port_en;
    logic                   rx_ovf;
    logic [2:0]             meta;
    logic [2:0]             syncd;
    logic                   sck_prev;
    logic                   mst;
    logic                   framed;
    logic                   gen_sync;
    logic                   cke_eff;
    logic                   smp_eff;
    logic                   cpol;
    logic [5:0]             nbits;
    logic [5:0]             nedges;
    logic [5:0]             ecnt;
    logic                   sel_ok;
    logic                   sync_in_act;
    logic                   run;
    logic                   tick;
    logic                   sclk;
    logic                   s_edge;
    logic                   lead;
    logic                   trail;
    logic                   in_shift;
    logic                   chg;
    logic                   m_term;
    logic                   do_shift;
    logic                   do_sample;
    logic                   done;
    logic                   start;
    logic                   sync_act;
    logic [15:0]            tx_sh;
    logic [15:0]            rx_sh;
    logic [15:0]            rx_next;
    logic [15:0]            rx_word;
    logic [AW:0]            limit;
    logic                   tx_full;
    logic                   tx_empty;
    logic [15:0]            tx_rdata;
    logic                   rx_full;
    logic                   rx_empty;
    logic [15:0]            rx_rdata;
    logic                   setup;
    logic                   wr;
    logic                   rd;
    logic                   mapped;
    logic [31:0]            rd_mux;

    // Pin inputs: two flops each before any logic looks at them
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    meta[gi]  <= 1'b0;
                    syncd[gi] <= 1'b0;
                end else begin
                    meta[gi]  <= pin_in[gi];
                    syncd[gi] <= meta[gi];
                end
            end
        end
    endgenerate
    assign pin_s = syncd;

    // Mode decode from the control registers
    assign mst      = c1.master_select; // RULE_11
    assign framed   = c2.framed_enable;
    assign cpol     = c1.clock_idle_polarity;
    assign gen_sync = framed & ~c2.frame_pulse_direction; // RULE_14
    assign cke_eff  = c1.clock_edge_select & ~framed; // RULE_07
    assign smp_eff  = c1.input_sample_phase & mst; // RULE_05
    assign nbits    = c1.word_width_select ? spc_pkg::BITS_WIDE : spc_pkg::BITS_NARROW; // RULE_03
    assign nedges   = {nbits[4:0], 1'b0};
    // Framing takes the pin over, so the select input is moot then
    assign sel_ok = framed | ~c1.select_pin_enable | ~pin_s.select_or_sync_pin; // RULE_08 RULE_09
    assign sync_in_act = pin_s.select_or_sync_pin == c2.frame_pulse_polarity; // RULE_15
    assign limit = c2.enhanced_buffer_enable ? (AW + 1)'(DEPTH) : (AW + 1)'(1); // RULE_17

    // Master clock runs only in a transfer, or all the time when framed
    assign run = port_en & mst & (framed | (st == spc_pkg::ST_SHIFT)); // RULE_20 RULE_22

    spc_prescaler u_presc (
        .mclk  (mclk),
        .reset (reset),
        .run   (run),
        .pri   (c1.primary_divider),
        .sec   (c1.secondary_divider),
        .tick  (tick)
    );

    // Slave clock edges, taken from the second sync flop only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= pin_s.shift_clock_pin;
        end
    end

    // Leading edge leaves idle level, trailing edge returns to it
    assign s_edge = pin_s.shift_clock_pin != sck_prev;
    assign lead   = mst ? tick & (sclk == cpol) : s_edge & (pin_s.shift_clock_pin != cpol);
    assign trail  = mst ? tick & (sclk != cpol) : s_edge & (pin_s.shift_clock_pin == cpol);
    assign in_shift = (st == spc_pkg::ST_SHIFT) && (ecnt < nedges);
    assign chg      = cke_eff ? trail : lead; // RULE_06
    // Master adds one quiet half period so the last bit can be sampled late
    assign m_term   = mst & tick & (st == spc_pkg::ST_SHIFT) & (ecnt == nedges);
    assign do_shift = in_shift & chg & (ecnt != '0); // RULE_06
    assign do_sample = smp_eff ? (in_shift & chg & (ecnt != '0)) | (m_term & ~cke_eff)
                               : in_shift & (cke_eff ? lead : trail); // RULE_04
    assign done  = mst ? m_term : in_shift & (lead | trail) & (ecnt == nedges - 6'h01);
    assign start = framed ? lead & (gen_sync ? ~tx_empty : sync_in_act)
                          : (mst ? ~tx_empty : sel_ok);
    assign rx_next = do_sample ? {rx_sh[14:0], pin_s.serial_data_in_pin} : rx_sh; // RULE_23
    assign rx_word = c1.word_width_select ? rx_next : {8'h00, rx_next[7:0]}; // RULE_03

    // Transfer sequencer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st    <= spc_pkg::ST_IDLE;
            ecnt  <= '0;
            tx_sh <= '0;
            rx_sh <= '0;
        end else if (!port_en) begin // RULE_21
            st   <= spc_pkg::ST_IDLE;
            ecnt <= '0;
        end else begin
            rx_sh <= rx_next;
            if (do_shift) begin
                tx_sh <= {tx_sh[14:0], 1'b0}; // RULE_23
            end
            unique case (st)
                spc_pkg::ST_IDLE: begin
                    if (start) begin
                        st    <= (framed && !c2.frame_pulse_edge) ? spc_pkg::ST_SYNC
                                                                  : spc_pkg::ST_SHIFT; // RULE_16
                        ecnt  <= framed ? spc_pkg::FRAMED_FIRST : '0;
                        tx_sh <= tx_empty ? '0 : tx_rdata;
                    end
                end
                spc_pkg::ST_SYNC: begin
                    if (lead) begin
                        st   <= spc_pkg::ST_SHIFT;
                        ecnt <= spc_pkg::FRAMED_FIRST;
                    end
                end
                spc_pkg::ST_SHIFT: begin
                    if (done || (!mst && !sel_ok)) begin // RULE_08
                        st <= spc_pkg::ST_IDLE;
                    end else if (in_shift && (lead || trail)) begin
                        ecnt <= ecnt + 6'h01;
                    end
                end
                default: begin
                    st <= spc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Internal master clock level
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclk <= 1'b0;
        end else if (!port_en || (!framed && st == spc_pkg::ST_IDLE)) begin
            sclk <= cpol; // RULE_10
        end else if (tick && (framed || in_shift)) begin
            sclk <= ~sclk; // RULE_20
        end
    end

    // Frame pulse spans one bit, before or on the first bit
    assign sync_act = gen_sync & ((st == spc_pkg::ST_SYNC) ||
                      ((st == spc_pkg::ST_SHIFT) && c2.frame_pulse_edge &&
                       (ecnt < spc_pkg::PULSE_EDGE_END))); // RULE_16

    // Pin drivers, all registered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_oe.shift_clock_pin     <= port_en & mst & ~c1.clock_pin_disable; // RULE_01 RULE_21
            pin_oe.serial_data_out_pin <= port_en & ~c1.data_out_pin_disable; // RULE_02
            pin_oe.select_or_sync_pin  <= port_en & gen_sync; // RULE_13
            pin_out.shift_clock_pin     <= sclk;
            pin_out.serial_data_out_pin <= c1.word_width_select ? tx_sh[15] : tx_sh[7]; // RULE_23
            pin_out.select_or_sync_pin  <= sync_act ~^ c2.frame_pulse_polarity; // RULE_15
        end
    end

    // APB decode; no wait state, and every answer still leaves a flop
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;
    assign rd    = psel & penable & pready & ~pwrite;
    assign wstat = spc_pkg::spc_status_t'(pwdata[15:0]);
    assign status = '{port_enable: port_en, rsvd_a: '0, rx_overflow: rx_ovf,
                      rsvd_b: '0, tx_full: tx_full, rx_full: ~rx_empty};

    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        case (paddr)
            spc_pkg::OFS_CTRL_ONE: rd_mux = {16'h0000, c1}; // RULE_18
            spc_pkg::OFS_CTRL_TWO: rd_mux = {16'h0000, c2};
            spc_pkg::OFS_STATUS:   rd_mux = {16'h0000, status};
            spc_pkg::OFS_DATA:     rd_mux = {16'h0000, rx_empty ? 16'h0000 : rx_rdata};
            default:               mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= rd_mux;
            end
        end
    end

    // Control registers; unused positions are never stored
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            c1      <= spc_pkg::spc_ctrl_one_t'(spc_pkg::CTRL_ONE_RST); // RULE_18
            c2      <= spc_pkg::spc_ctrl_two_t'(spc_pkg::CTRL_TWO_RST);
            port_en <= 1'b0;
        end else if (wr) begin
            if (paddr == spc_pkg::OFS_CTRL_ONE) begin
                c1 <= spc_pkg::spc_ctrl_one_t'(pwdata[15:0] & spc_pkg::CTRL_ONE_MASK); // RULE_18
            end
            if (paddr == spc_pkg::OFS_CTRL_TWO) begin
                c2 <= spc_pkg::spc_ctrl_two_t'(pwdata[15:0] & spc_pkg::CTRL_TWO_MASK);
            end
            if (paddr == spc_pkg::OFS_STATUS) begin
                port_en <= wstat.port_enable; // RULE_21
            end
        end
    end

    // Overflow is sticky; a new overflow beats a write-one clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_ovf <= 1'b0;
        end else begin
            rx_ovf <= (done & rx_full) |
                      (rx_ovf & ~(wr && paddr == spc_pkg::OFS_STATUS && wstat.rx_overflow));
        end
    end

    spc_fifo #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_txq (
        .mclk  (mclk),
        .reset (reset),
        .limit (limit),
        .push  (wr && paddr == spc_pkg::OFS_DATA),
        .wdata (pwdata[15:0]),
        .pop   (port_en && st == spc_pkg::ST_IDLE && start),
        .rdata (tx_rdata),
        .full  (tx_full),
        .empty (tx_empty)
    );

    // A finished word that finds the receive side full is dropped
    spc_fifo #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_rxq (
        .mclk  (mclk),
        .reset (reset),
        .limit (limit),
        .push  (port_en && done),
        .wdata (rx_word),
        .pop   (rd && paddr == spc_pkg::OFS_DATA),
        .rdata (rx_rdata),
        .full  (rx_full),
        .empty (rx_empty)
    );

    // Sample counter used only by the checks below
    logic [5:0] chk_smp;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            chk_smp <= '0;
        end else if (st != spc_pkg::ST_SHIFT) begin
            chk_smp <= '0;
        end else if (do_sample) begin
            chk_smp <= chk_smp + 6'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_CLK_PIN_OFF: assert property ($past(c1.clock_pin_disable) |-> !pin_oe.shift_clock_pin) // RULE_01
        else $error("clock pin driven while disabled");
    AST_SDO_PIN: assert property (##1 pin_oe.serial_data_out_pin ==
                                  $past(port_en && !c1.data_out_pin_disable)) // RULE_02
        else $error("data pin enable mismatch");
    AST_SAMPLE_COUNT: assert property (done && port_en |-> chk_smp + 6'(do_sample) == nbits) // RULE_03
        else $error("word did not take the selected bit count");
    AST_IDLE_LEVEL: assert property ((port_en && !framed && st == spc_pkg::ST_IDLE &&
                                      $stable(cpol)) [*2] |-> sclk == cpol) // RULE_10
        else $error("idle clock level wrong");
    AST_MASTER_CLK: assert property (pin_oe.shift_clock_pin |-> $past(mst && port_en)) // RULE_11
        else $error("clock pin driven in slave mode");
    AST_SYNC_DIR: assert property (pin_oe.select_or_sync_pin |->
                                   $past(framed && !c2.frame_pulse_direction)) // RULE_14
        else $error("sync pin driven while input");
    AST_SYNC_IDLE: assert property ((gen_sync && !sync_act && $stable(c2)) [*2] |->
                                    pin_out.select_or_sync_pin == !c2.frame_pulse_polarity) // RULE_15
        else $error("sync pin idle level wrong");
    AST_PRE_PULSE: assert property (st == spc_pkg::ST_SHIFT && $past(st) != spc_pkg::ST_SHIFT &&
                                    framed && !c2.frame_pulse_edge |->
                                    $past(st) == spc_pkg::ST_SYNC) // RULE_16
        else $error("frame started without lead pulse");
    AST_RSVD_ZERO: assert property (c1.rsvd == '0 && c2.rsvd == '0 &&
                                    (!pready || prdata[31:16] == 16'h0000)) // RULE_18
        else $error("reserved bits not zero");
    AST_DISABLE: assert property (!port_en |=> st == spc_pkg::ST_IDLE ##1
                                  (st != spc_pkg::ST_SHIFT || $past(port_en && start))) // RULE_21
        else $error("engine active while port disabled");
    AST_APB_WAIT: assert property (setup |=> pready ##1 !pready)
        else $error("APB ready timing wrong");
endmodule
`default_nettype wire

/* File: tb/spc_peer.sv */
// Behavioural external serial peripheral answering the port in master mode
`timescale 1ns/1ps
`default_nettype none
module spc_peer (
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic        cpol,
    input  wire logic        wide,
    output logic             miso,
    output logic      [15:0] rx_word
);
    logic [15:0] sh;

    // Reply word is loaded while the clock idles
    task automatic load(input logic [15:0] w);
        sh = w;
        rx_word = 16'h0000;
    endtask

    initial begin
        sh = 16'h0000;
        miso = 1'b0;
        rx_word = 16'h0000;
    end

    // Reply moves on the leading edge, capture on the trailing edge
    always @(sck) begin
        if (sck !== cpol) begin
            miso = wide ? sh[15] : sh[7];
            sh = sh << 1;
        end else begin
            rx_word = {rx_word[14:0], mosi};
        end
    end
endmodule
`default_nettype wire

/* File: tb/spc_port_bench.sv */
// Register and master transfer checks of the serial port
`timescale 1ns/1ps
`default_nettype none
module spc_port_bench;
    logic                  mclk;
    logic                  reset;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cpol;
    logic                  wide;
    logic                  miso;
    logic                  sck;
    logic [15:0]           peer_rx;
    logic [31:0]           q;
    logic                  err;
    int                    fails;
    int                    num_checks;
    int                    toggles;
    spc_pkg::spc_pin_t     pin_out;
    spc_pkg::spc_pin_t     pin_oe;
    spc_pkg::spc_pin_in_t  pin_in;

    // Undriven clock pin is pulled to its idle level
    assign sck = pin_oe.shift_clock_pin ? pin_out.shift_clock_pin : cpol;
    assign pin_in = {sck, miso, 1'b1};

    spc_port uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    spc_peer peer (.sck(sck), .mosi(pin_out.serial_data_out_pin), .cpol(cpol),
        .wide(wide), .miso(miso), .rx_word(peer_rx));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; answer taken at the rising edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 20) begin
                fails++;
                final_report();
            end
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    initial begin
        fails = 0;
        num_checks = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cpol = 1'b0;
        wide = 1'b0;
        reset = 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(0, spc_pkg::OFS_CTRL_ONE, 0); chk("one_rst", q, 32'h0000);
        apb(0, spc_pkg::OFS_CTRL_TWO, 0); chk("two_rst", q, 32'h0000);
        apb(1, spc_pkg::OFS_CTRL_ONE, 32'hFFFF);
        apb(0, spc_pkg::OFS_CTRL_ONE, 0); chk("one_mask", q, 32'h1FFF);
        apb(1, spc_pkg::OFS_CTRL_TWO, 32'hFFFF);
        apb(0, spc_pkg::OFS_CTRL_TWO, 0); chk("two_mask", q, 32'hE003);
        apb(0, 8'h10, 0); chk("unmapped", {31'h0, err}, 32'h1);
        apb(1, spc_pkg::OFS_CTRL_TWO, 0);
        // Master words of both widths: divider 4 x 2 gives four cycles a half period
        for (int i = 0; i < 2; i++) begin
            wide = i[0];
            apb(1, spc_pkg::OFS_CTRL_ONE, 32'h003A | (i << 10));
            apb(1, spc_pkg::OFS_STATUS, 32'h8000);
            // Pin enables leave a flop one edge after the enable lands
            @(negedge mclk);
            chk("oe", {29'h0, pin_oe}, 32'h6);
            @(posedge mclk);
            peer.load(16'hC3A5);
            apb(1, spc_pkg::OFS_DATA, 32'h5A96);
            q = 0;
            for (int n = 0; n < 100 && q[0] !== 1'b1; n++) apb(0, spc_pkg::OFS_STATUS, 0);
            chk("rx_ready", {31'h0, q[0]}, 32'h1);
            apb(0, spc_pkg::OFS_DATA, 0);
            chk("rx_word", q, i ? 32'hC3A5 : 32'h00A5);
            chk("tx_word", {16'h0, peer_rx}, i ? 32'h5A96 : 32'h0096);
            chk("sck_idle", {31'h0, pin_out.shift_clock_pin}, 32'h0);
        end
        // Framed master without data: clock runs free, sync idles inactive
        apb(1, spc_pkg::OFS_CTRL_TWO, 32'h8000);
        apb(0, spc_pkg::OFS_CTRL_TWO, 0);
        chk("fr_two", q, 32'h8000);
        @(negedge mclk);
        chk("fr_oe", {29'h0, pin_oe}, 32'h7);
        chk("fr_sync", {31'h0, pin_out.select_or_sync_pin}, 32'h1);
        toggles = 0;
        repeat (40) begin
            err = pin_out.shift_clock_pin;
            @(negedge mclk);
            toggles += int'(err != pin_out.shift_clock_pin);
        end
        chk("fr_clk", toggles, 32'hA);
        @(posedge mclk);
        apb(1, spc_pkg::OFS_CTRL_TWO, 0);
        cpol = 1'b1;
        apb(1, spc_pkg::OFS_CTRL_ONE, 32'h007A);
        apb(0, spc_pkg::OFS_CTRL_ONE, 0);
        chk("sck_cpol", {31'h0, pin_out.shift_clock_pin}, 32'h1);
        apb(1, spc_pkg::OFS_CTRL_ONE, 32'h187A);
        apb(0, spc_pkg::OFS_CTRL_ONE, 0);
        chk("oe_dis", {29'h0, pin_oe}, 32'h0);
        apb(1, spc_pkg::OFS_CTRL_ONE, 32'h003A);
        apb(1, spc_pkg::OFS_STATUS, 32'h0000);
        apb(0, spc_pkg::OFS_STATUS, 0);
        chk("oe_off", {29'h0, pin_oe}, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
